// File: tccr_pkg.sv
// Package: offsets, field layouts, reset values and carriers for the touch channel config bank
package tccr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_POLARITY = 8'h1c;
  localparam logic [7:0] OFS_SCALE    = 8'h1e;
  localparam logic [7:0] OFS_SENSOR0  = 8'h20;
  localparam logic [7:0] OFS_SENSOR1  = 8'h22;
  localparam logic [7:0] OFS_SENSOR2  = 8'h24;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_POLARITY = 8'h0f;
  localparam logic [7:0] RST_SCALE    = 8'h55;
  localparam logic [7:0] RST_SENSOR   = 8'h04;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int PIN_POL_LSB  = 4;
  localparam int DIR_LSB      = 0;
  localparam int RANGE_BIT    = 7;
  localparam int BAND_MSB     = 6;
  localparam int BAND_LSB     = 5;
  localparam int CYCLE_MSB    = 4;
  localparam int CYCLE_LSB    = 0;
  localparam logic [1:0] BAND_RESERVED = 2'h3;

  // Sensor config fields for one channel
  typedef struct packed {
    logic       resistance_range;
    logic [1:0] frequency_band;
    logic [4:0] cycle_count;
  } tccr_sensor_type;

  // Host register access request
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tccr_req_type;

endpackage

// File: tccr_pin_drive.sv
`timescale 1ns/1ps
// Module: one button output pin with programmable polarity
module tccr_pin_drive (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic pressed,
  input  wire logic active_high,
  // Pin
  output logic      pin
);

  logic pin_reg;
  logic pin_next;

  // Released state is the inactive level: high for active low, low for active high
  always_comb begin
    pin_next = pressed ~^ active_high;
  end

  // Registered so the pin never glitches on a polarity write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= 1'b1;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign pin = pin_reg;

endmodule // tccr_pin_drive

// File: tccr_config_regs.sv
`timescale 1ns/1ps
// Module: polarity and counter scale registers for four channels, sensor configuration registers for channels 0 to 2
module tccr_config_regs #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Register access
  input  wire tccr_pkg::tccr_req_type req,
  output logic [7:0]                  rdata,
  output logic                        rvalid,
  output logic                        band_reject,
  // Button inputs from the button algorithm
  input  wire logic [CHANNELS-1:0]    button_pressed,
  // Button pins
  output logic [CHANNELS-1:0]         button_pin,
  // Configuration out to the measurement path
  output logic [CHANNELS-1:0]         value_direction,
  output logic [2*CHANNELS-1:0]       count_scale,
  output tccr_pkg::tccr_sensor_type   sensor_cfg_ch0,
  output tccr_pkg::tccr_sensor_type   sensor_cfg_ch1,
  output tccr_pkg::tccr_sensor_type   sensor_cfg_ch2
);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  // The polarity and scale bytes pack exactly four channels, so no other count fits
  if (CHANNELS != 4) begin : g_channel_check
    $error("tccr_config_regs supports exactly four channels");
  end

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [7:0] polarity_reg;
  logic [7:0] polarity_next;
  logic [7:0] scale_reg;
  logic [7:0] scale_next;
  logic [7:0] sensor_reg  [3];
  logic [7:0] sensor_next [3];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       reject_reg;
  logic       reject_next;
  logic       hit_polarity;
  logic       hit_scale;
  logic [1:0] hit_sensor;
  logic       sensor_write_ok;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Index of the sensor register hit by an address, 3 when none
  function automatic logic [1:0] sensor_index(input logic [7:0] a);
    unique case (a)
      tccr_pkg::OFS_SENSOR0: sensor_index = 2'h0;
      tccr_pkg::OFS_SENSOR1: sensor_index = 2'h1;
      tccr_pkg::OFS_SENSOR2: sensor_index = 2'h2;
      default:               sensor_index = 2'h3;
    endcase
  endfunction

  // True when a byte carries the reserved frequency band code
  function automatic logic band_is_reserved(input logic [7:0] d);
    band_is_reserved = (d[tccr_pkg::BAND_MSB:tccr_pkg::BAND_LSB] == tccr_pkg::BAND_RESERVED);
  endfunction

  // One decode shared by the write and read paths, so both always agree on the map
  always_comb begin
    hit_polarity    = (req.addr == tccr_pkg::OFS_POLARITY);
    hit_scale       = (req.addr == tccr_pkg::OFS_SCALE);
    hit_sensor      = sensor_index(req.addr);
    sensor_write_ok = req.write && (hit_sensor != 2'h3) && !band_is_reserved(req.wdata);
  end

  // ---------------------------------------------------------------------------
  // Polarity and counter scale
  // ---------------------------------------------------------------------------
  // Polarity byte: pin polarity in the upper nibble, value direction below
  always_comb begin
    polarity_next = polarity_reg;
    if (req.write && hit_polarity) begin
      polarity_next = req.wdata;
    end
  end

  // Reset leaves every pin active low and every value rising with frequency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      polarity_reg <= tccr_pkg::RST_POLARITY;
    end else begin
      polarity_reg <= polarity_next;
    end
  end

  // Counter scale: all four two-bit fields are written as one byte
  always_comb begin
    scale_next = scale_reg;
    if (req.write && hit_scale) begin
      scale_next = req.wdata;
    end
  end

  // Every scale field comes out of reset at one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scale_reg <= tccr_pkg::RST_SCALE;
    end else begin
      scale_reg <= scale_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Sensor configuration, channels 0 to 2
  // ---------------------------------------------------------------------------
  // A reserved band drops the whole byte, so range and cycle count stay coherent
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sensor_next[i] = sensor_reg[i];
    end
    if (sensor_write_ok) begin
      sensor_next[hit_sensor] = req.wdata;
    end
  end

  // All three sensors reset to the same byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        sensor_reg[i] <= tccr_pkg::RST_SENSOR;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        sensor_reg[i] <= sensor_next[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  // A read in the same cycle as a write sees the old byte; unmapped offsets read zero
  always_comb begin
    rvalid_next = req.read;
    rdata_next  = 8'h00;
    if (req.read) begin
      if (hit_polarity) begin
        rdata_next = polarity_reg;
      end else if (hit_scale) begin
        rdata_next = scale_reg;
      end else if (hit_sensor != 2'h3) begin
        rdata_next = sensor_reg[hit_sensor];
      end
    end
  end

  // Data is held at zero between reads so a stale byte never lingers on the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Reserved band flag
  // ---------------------------------------------------------------------------
  // One-cycle pulse per dropped sensor write; the byte itself is left untouched
  always_comb begin
    reject_next = req.write && (hit_sensor != 2'h3) && band_is_reserved(req.wdata);
  end

  // Registered so the flag lines up with the read answer timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reject_reg <= 1'b0;
    end else begin
      reject_reg <= reject_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rdata           = rdata_reg;
  assign rvalid          = rvalid_reg;
  assign band_reject     = reject_reg;
  assign value_direction = polarity_reg[tccr_pkg::DIR_LSB +: CHANNELS];
  assign count_scale     = scale_reg;
  assign sensor_cfg_ch0  = tccr_pkg::tccr_sensor_type'(sensor_reg[0]);
  assign sensor_cfg_ch1  = tccr_pkg::tccr_sensor_type'(sensor_reg[1]);
  assign sensor_cfg_ch2  = tccr_pkg::tccr_sensor_type'(sensor_reg[2]);

  // One pin driver per channel
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_pin
      tccr_pin_drive u_pin (
        .clk         (clk),
        .rst_n       (rst_n),
        .pressed     (button_pressed[g]),
        .active_high (polarity_reg[tccr_pkg::PIN_POL_LSB + g]),
        .pin         (button_pin[g])
      );
    end
  endgenerate

endmodule // tccr_config_regs

// File: tccr_config_regs_assertions.sv
// Checker: access timing and field updates of the config bank
`timescale 1ns/1ps
module tccr_chk #(parameter int CHANNELS = 4) (
  // Host access
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire tccr_pkg::tccr_req_type    req,
  input wire logic [7:0]                rdata,
  input wire logic                      rvalid,
  input wire logic                      band_reject,
  // Configuration outputs
  input wire logic [CHANNELS-1:0]       value_direction,
  input wire logic [2*CHANNELS-1:0]     count_scale,
  input wire tccr_pkg::tccr_sensor_type sensor_cfg_ch0
);
  logic bad;
  // Sensor write carrying the reserved band code; must be dropped
  assign bad = req.write && req.addr inside {8'h20, 8'h22, 8'h24} && req.wdata[6:5] == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_ans_a: assert property (req.read |=> rvalid) else $error("read lost");
  rd_idle_a: assert property (!req.read |=> !rvalid && rdata == 8'h00) else $error("stray read");
  band_flag_a: assert property (bad |=> band_reject) else $error("no reject");
  flag_only_a: assert property (!bad |=> !band_reject) else $error("false reject");
  band_keep_a: assert property (bad |=> $stable(sensor_cfg_ch0)) else $error("band kept");
  s0_wr_a: assert property (req.write && req.addr == 8'h20 && !bad |=> sensor_cfg_ch0 == $past(req.wdata))
    else $error("sensor lost");
  dir_wr_a: assert property (req.write && req.addr == 8'h1c |=> value_direction == $past(req.wdata[3:0]))
    else $error("direction lost");
  scale_wr_a: assert property (req.write && req.addr == 8'h1e |=> count_scale == $past(req.wdata))
    else $error("scale lost");
  cover property (bad);
  cover property (rvalid && rdata != 8'h00);
  cover property (req.write ##1 req.read);
endmodule // tccr_chk
bind tccr_config_regs tccr_chk #(.CHANNELS(CHANNELS)) u_chk (
  .clk             (clk),
  .rst_n           (rst_n),
  .req             (req),
  .rdata           (rdata),
  .rvalid          (rvalid),
  .band_reject     (band_reject),
  .value_direction (value_direction),
  .count_scale     (count_scale),
  .sensor_cfg_ch0  (sensor_cfg_ch0)
);

// File: touch_channel_config_regs_tb.sv
// Testbench: directed and random traffic for the config bank
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("ERROR %0t %h %h", $time, g, e); end end
module touch_channel_config_regs_tb;
  logic                      clk = 1'b0, rst_n = 1'b0, rvalid, band_reject;
  logic [3:0]                button_pressed = 4'h0, button_pin, value_direction;
  logic [7:0]                rdata, count_scale, ofs [7] = '{8'h1c, 8'h1e, 8'h20, 8'h22, 8'h24, 8'h21, 8'hff};
  // Model bytes in slot order: polarity, scale, sensors 0 to 2
  logic [7:0]                m [5] = '{8'h0f, 8'h55, 8'h04, 8'h04, 8'h04};
  tccr_pkg::tccr_req_type    req = '0;
  tccr_pkg::tccr_sensor_type sensor_cfg_ch0, sensor_cfg_ch1, sensor_cfg_ch2;
  int                        err_count = 0, check_count = 0;
  tccr_config_regs #(.CHANNELS(4)) dut (.clk, .rst_n, .req, .rdata, .rvalid, .band_reject, .button_pressed,
    .button_pin, .value_direction, .count_scale, .sensor_cfg_ch0, .sensor_cfg_ch1, .sensor_cfg_ch2);
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Counts, then verdict; shared with the watchdog
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Model slot of an offset, -1 when nothing lives there
  function automatic int slot(input logic [7:0] a);
    case (a)
      8'h1c:   return 0;
      8'h1e:   return 1;
      8'h20:   return 2;
      8'h22:   return 3;
      8'h24:   return 4;
      default: return -1;
    endcase
  endfunction
  // A sensor byte carrying band code 3 must be dropped whole
  function automatic logic dropped(input logic [7:0] a, d);
    return slot(a) >= 2 && d[6:5] == 2'h3;
  endfunction
  // Pin level per channel: a pressed button shows at its active level
  function automatic logic [3:0] pin_level(input logic [3:0] p, pol);
    for (int c = 0; c < 4; c++) pin_level[c] = pol[c] ? p[c] : !p[c];
  endfunction
  // Write, read straight back, then judge outputs after an idle cycle
  task automatic acc(input logic [7:0] ad, d);
    int   s;
    logic bad;
    s   = slot(ad);
    bad = dropped(ad, d);
    req = '{1'b1, 1'b0, ad, d};
    @(negedge clk) req = '{1'b0, 1'b1, ad, 8'h00};
    `CHK(band_reject, bad)
    if (!bad && s >= 0) m[s] = d;
    @(negedge clk) req = '0;
    `CHK({rvalid, rdata}, {1'b1, s >= 0 ? m[s] : 8'h00})
    @(negedge clk);
    `CHK({button_pin, value_direction}, {pin_level(button_pressed, m[0][7:4]), m[0][3:0]})
    `CHK(count_scale, m[1])
    `CHK({sensor_cfg_ch0, sensor_cfg_ch1, sensor_cfg_ch2}, {m[2], m[3], m[4]})
  endtask
  // Write and read one mapped byte in the same cycle: the read returns the old byte
  task automatic rw_same(input logic [7:0] ad, d);
    int s;
    s   = slot(ad);
    req = '{1'b1, 1'b1, ad, d};
    @(negedge clk) req = '0;
    `CHK({rvalid, rdata, band_reject}, {1'b1, m[s], dropped(ad, d)})
    if (!dropped(ad, d)) m[s] = d;
    @(negedge clk);
  endtask
  // Reset in mid-run: every byte and pin returns to its reset level
  task automatic mid_reset;
    rst_n = 1'b0;
    @(negedge clk);
    `CHK({rvalid, band_reject, button_pin}, {1'b0, 1'b0, 4'hf})
    `CHK({value_direction, count_scale}, {4'hf, 8'h55})
    `CHK({sensor_cfg_ch0, sensor_cfg_ch1, sensor_cfg_ch2}, {3{8'h04}})
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    m     = '{8'h0f, 8'h55, 8'h04, 8'h04, 8'h04};
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h415d));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    acc(8'hff, 8'h00);
    // Every band code on each sensor, extreme range and cycle fields
    for (int i = 2; i < 5; i++) for (int b = 0; b < 4; b++) acc(ofs[i], {b[0], b[1:0], b[0] ? 5'h1f : 5'h00});
    repeat (400) begin
      button_pressed = 4'($urandom);
      acc(ofs[$urandom_range(6, 0)], 8'($urandom));
    end
    // Same-cycle write and read on every register, then a reset in mid-run
    for (int i = 0; i < 5; i++) rw_same(ofs[i], 8'($urandom));
    acc(8'hff, 8'h00);
    mid_reset;
    acc(8'hff, 8'h00);
    end_sim;
  end
  // Watchdog far past the expected 1300 cycles
  initial begin
    #40000;
    err_count++;
    end_sim;
  end
endmodule // touch_channel_config_regs_tb
